// ===== inc/psmi_pkg.sv
// constants, types and register map of the step-motor indexer
// Notes on behaviour
// R01: one step per rising step edge only
// R02: forward: second winding lags first by 90
// R03: reverse: second winding leads first by 90
// R04: half/micro start: first 100%, second 0%
// R05: full-step start: both windings at +100%
// R06: after mode change hold position until step
// R07: first step jumps to next quadrant/half position
// R08: clear low ignores step, direction, controls
// R09: supply lockout acts like clear
// R10: overheat stops all circuits; here stepping, bridges and peak flags stop, registers and irq keep running
// R11: overheat ignored during clear or lockout
// R12: controller sets drive-select pins statically
// R13: targets signed, positive from A to B
// R14: clear resets position, bridges high impedance
// R15: force-off floats outputs, keeps position
// R16: peak flag low at documented peaks
// R17: microstep: 64 positions per period
// R18: direction sampled on each rising step
// R19: half: eight positions, full: four
package psmi_pkg;
	typedef enum logic [1:0] {MD_FULL, MD_HALF, MD_MICRO} psmi_mode_t;
	localparam int POS_W = 6;
	localparam logic [5:0] POS_START_AXIS = 6'h00;
	localparam logic [5:0] POS_START_DIAG = 6'h08;
	localparam logic [3:0] QUAD_DIAG = 4'h8;
	localparam logic [6:0] MAG_FULL = 7'h64;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
	localparam int IRQ_PEAK_A = 0;
	localparam int IRQ_PEAK_B = 1;
	localparam int IRQ_THERM = 2;
	localparam int ST_POS_B = 8;
	localparam int ST_THERM = 16;
	localparam int ST_HOLD = 17;
	localparam int ST_MODE = 18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== inc/psmi_if.sv
// position hand-off from indexer to waveform table
interface psmi_if;
	import psmi_pkg::*;
	logic [POS_W-1:0] pos;
	psmi_mode_t shape;
	modport src (output pos, output shape);
	modport dst (input pos, input shape);
endinterface

// ===== verilog/psmi_indexer.sv
// phase position counter of one channel pair
module psmi_indexer
	import psmi_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic step,
	input wire logic fwd,
	input wire psmi_mode_t mode,
	input wire logic hold,
	input wire logic freeze,
	psmi_if.src ix
);
	logic [POS_W-1:0] pos_r, pos_nxt;
	psmi_mode_t shape_r, shape_nxt;
	logic step_q_r, step_q_nxt;
	logic rise;
	logic [POS_W-1:0] init_pos;

	////////////////////////////////////////////////////////////////
	// step edge, position and held waveform shape
	always_comb
	begin
		step_q_nxt = step;
		rise = step & ~step_q_r; // R01
		init_pos = (mode == MD_FULL) ? POS_START_DIAG : POS_START_AXIS; // R04 R05
		pos_nxt = pos_r;
		shape_nxt = shape_r;
		if (hold)
		begin
			pos_nxt = init_pos; // R14 R08 R09
			shape_nxt = mode;
		end
		else if (rise && !freeze)
		begin
			shape_nxt = mode; // R06
			case (mode)
				MD_MICRO: pos_nxt = fwd ? pos_r + 6'h01 : pos_r - 6'h01; // R17 R18
				MD_HALF: pos_nxt = fwd ? (pos_r + 6'h08) & 6'h38 : (pos_r - 6'h01) & 6'h38; // R07 R19
				// same formula snaps any micro position to the next quadrant diagonal
				MD_FULL: pos_nxt = fwd ? ((pos_r + 6'h08) & 6'h30) + 6'h08
					: ((pos_r - 6'h09) & 6'h30) + 6'h08; // R07 R19
				default: pos_nxt = pos_r;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pos_r <= POS_START_AXIS;
			shape_r <= MD_MICRO;
			step_q_r <= 1'b0;
		end
		else
		begin
			pos_r <= pos_nxt;
			shape_r <= shape_nxt;
			step_q_r <= step_q_nxt;
		end
	end

	assign ix.pos = pos_r;
	assign ix.shape = shape_r;

	a_no_move_idle: assert property (@(posedge aclk) disable iff (!aresetn) // R01
		!hold && !rise |=> $stable(pos_r)) else $error("position moved without step");
	a_micro_fwd: assert property (@(posedge aclk) disable iff (!aresetn) // R18
		!hold && !freeze && rise && mode == MD_MICRO && fwd |=> pos_r == $past(pos_r) + 6'h01)
		else $error("micro forward step wrong");
	a_full_diag: assert property (@(posedge aclk) disable iff (!aresetn) // R07
		!hold && !freeze && rise && mode == MD_FULL |=> pos_r[3:0] == QUAD_DIAG)
		else $error("full step not on diagonal");
	a_clear_init: assert property (@(posedge aclk) disable iff (!aresetn) // R05
		hold && mode == MD_FULL |=> pos_r == POS_START_DIAG) else $error("full start wrong");
	c_micro_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
		pos_r == 6'h3f ##1 pos_r == 6'h00);
endmodule

// ===== verilog/psmi_wave.sv
// signed winding targets from phase position
module psmi_wave
	import psmi_pkg::*;
(
	psmi_if.dst ix,
	output logic signed [7:0] tgt_1,
	output logic signed [7:0] tgt_2,
	output logic peak
);
	logic [3:0] k;
	logic [6:0] m_lo, m_hi;
	logic signed [7:0] c, s;

	// typical magnitude in percent at quadrant index 0..16
	function automatic logic [6:0] mag(input logic [4:0] i);
		case (i)
			5'd0, 5'd1: mag = 7'h64;
			5'd2: mag = 7'h62;
			5'd3: mag = 7'h60;
			5'd4: mag = 7'h5c;
			5'd5: mag = 7'h58;
			5'd6: mag = 7'h53;
			5'd7: mag = 7'h4d;
			5'd8: mag = 7'h47;
			5'd9: mag = 7'h3f;
			5'd10: mag = 7'h38;
			5'd11: mag = 7'h2f;
			5'd12: mag = 7'h26;
			5'd13: mag = 7'h1d;
			5'd14: mag = 7'h14;
			5'd15: mag = 7'h0a;
			default: mag = 7'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// winding 1 is cosine, winding 2 sine of the same angle
	always_comb
	begin
		k = ix.pos[3:0];
		m_lo = mag({1'b0, k});
		m_hi = mag(5'd16 - {1'b0, k});
		case (ix.pos[5:4]) // R02 R03 R13
			2'd0:
			begin
				c = $signed({1'b0, m_lo});
				s = $signed({1'b0, m_hi});
			end
			2'd1:
			begin
				c = -$signed({1'b0, m_hi});
				s = $signed({1'b0, m_lo});
			end
			2'd2:
			begin
				c = -$signed({1'b0, m_lo});
				s = -$signed({1'b0, m_hi});
			end
			default:
			begin
				c = $signed({1'b0, m_hi});
				s = -$signed({1'b0, m_lo});
			end
		endcase
		if (ix.shape == MD_MICRO)
		begin
			tgt_1 = c;
			tgt_2 = s;
			peak = (k == 4'h0); // R16
		end
		else
		begin
			// coarse modes drive saturated levels with the table only giving the sign
			tgt_1 = (c > 0) ? $signed({1'b0, MAG_FULL}) : (c < 0) ? -$signed({1'b0, MAG_FULL}) : 8'sh00;
			tgt_2 = (s > 0) ? $signed({1'b0, MAG_FULL}) : (s < 0) ? -$signed({1'b0, MAG_FULL}) : 8'sh00;
			peak = (ix.pos == POS_START_DIAG); // R16
		end
	end
endmodule

// ===== verilog/psmi_top.sv
// two-pair stepping indexer with register slave and interrupt
module psmi_top
	import psmi_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic chip_clear_low,
	input wire logic supply_low_lockout,
	input wire logic thermal_shutdown,
	input wire logic step_pulse_pair_a,
	input wire logic step_pulse_pair_b,
	input wire logic rotation_select_pair_a,
	input wire logic rotation_select_pair_b,
	input wire logic drive_select_pin_1,
	input wire logic drive_select_pin_2,
	input wire logic drive_select_pin_3,
	input wire logic drive_select_pin_4,
	input wire logic output_force_off_pair_a,
	input wire logic output_force_off_pair_b,
	output logic signed [7:0] target_w1_pair_a,
	output logic signed [7:0] target_w2_pair_a,
	output logic signed [7:0] target_w1_pair_b,
	output logic signed [7:0] target_w2_pair_b,
	output logic bridge_en_pair_a,
	output logic bridge_en_pair_b,
	output logic phase_peak_flag_pair_a_o,
	output logic phase_peak_flag_pair_a_oe,
	output logic phase_peak_flag_pair_b_o,
	output logic phase_peak_flag_pair_b_oe,
	output logic irq
);
	psmi_mode_t mode;
	logic hold, therm_stop;
	logic [1:0] step_in, fwd_in, off_n_in, peak_w;
	logic [7:0] w1_w [2];
	logic [7:0] w2_w [2];
	logic [5:0] pos_w [2];
	psmi_mode_t shape_w [2];
	logic [7:0] w1_r [2];
	logic [7:0] w1_nxt [2];
	logic [7:0] w2_r [2];
	logic [7:0] w2_nxt [2];
	logic [1:0] en_r, en_nxt, pk_r, pk_nxt;

	////////////////////////////////////////////////////////////////
	// pin decode; pins 3 and 4 serve the plain-bridge modes left outside this block
	always_comb
	begin
		if (drive_select_pin_2)
			mode = MD_MICRO;
		else if (drive_select_pin_1)
			mode = MD_HALF;
		else
			mode = MD_FULL;
		hold = !chip_clear_low || supply_low_lockout; // R08 R09
		therm_stop = thermal_shutdown && !hold; // R10 R11
		step_in = {step_pulse_pair_b, step_pulse_pair_a};
		fwd_in = {rotation_select_pair_b, rotation_select_pair_a};
		off_n_in = {output_force_off_pair_b, output_force_off_pair_a};
	end

	////////////////////////////////////////////////////////////////
	// one indexer and waveform table per channel pair
	for (genvar g = 0; g < 2; g++)
	begin : g_pair
		psmi_if ixb ();
		psmi_indexer u_idx (
			.aclk(aclk),
			.aresetn(aresetn),
			.step(step_in[g]),
			.fwd(fwd_in[g]),
			.mode(mode),
			.hold(hold),
			.freeze(therm_stop),
			.ix(ixb.src)
		);
		psmi_wave u_wave (
			.ix(ixb.dst),
			.tgt_1(w1_w[g]),
			.tgt_2(w2_w[g]),
			.peak(peak_w[g])
		);
		assign pos_w[g] = ixb.pos;
		assign shape_w[g] = ixb.shape;
		// outputs float on clear, lockout, overheat or force-off; position is kept on overheat and force-off
		always_comb
		begin
			en_nxt[g] = !hold && !therm_stop && off_n_in[g]; // R14 R15 R10
			w1_nxt[g] = w1_w[g];
			w2_nxt[g] = w2_w[g];
			pk_nxt[g] = en_nxt[g] && peak_w[g]; // R16 R15
		end
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				w1_r[g] <= 8'h00;
				w2_r[g] <= 8'h00;
				en_r[g] <= 1'b0;
				pk_r[g] <= 1'b0;
			end
			else
			begin
				w1_r[g] <= w1_nxt[g];
				w2_r[g] <= w2_nxt[g];
				en_r[g] <= en_nxt[g];
				pk_r[g] <= pk_nxt[g];
			end
		end
	end

	assign target_w1_pair_a = w1_r[0];
	assign target_w2_pair_a = w2_r[0];
	assign target_w1_pair_b = w1_r[1];
	assign target_w2_pair_b = w2_r[1];
	assign bridge_en_pair_a = en_r[0];
	assign bridge_en_pair_b = en_r[1];
	// open drain: only ever pulls low
	assign phase_peak_flag_pair_a_o = 1'b0;
	assign phase_peak_flag_pair_b_o = 1'b0;
	assign phase_peak_flag_pair_a_oe = pk_r[0];
	assign phase_peak_flag_pair_b_oe = pk_r[1];

	////////////////////////////////////////////////////////////////
	// sticky events: peak entry per pair and overheat entry
	logic [2:0] ist_r, ist_nxt, ien_r, ien_nxt, ev;
	logic therm_q_r, therm_q_nxt;
	logic [2:0] clr;

	always_comb
	begin
		therm_q_nxt = therm_stop;
		ev = {therm_stop & ~therm_q_r, pk_nxt & ~pk_r};
		ist_nxt = (ist_r & ~clr) | ev; // set beats clear
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ist_r <= 3'h0;
			therm_q_r <= 1'b0;
		end
		else
		begin
			ist_r <= ist_nxt;
			therm_q_r <= therm_q_nxt;
		end
	end

	assign irq = |(ist_r & ien_r);

	////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bv_r, bv_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic [1:0] br_r, br_nxt;
	logic do_wr;

	always_comb
	begin
		aw_ok_nxt = aw_ok_r;
		w_ok_nxt = w_ok_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		ien_nxt = ien_r;
		clr = 3'h0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_ok_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_ok_nxt = 1'b1;
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
		end
		do_wr = aw_ok_r && w_ok_r && !bv_r;
		if (do_wr)
		begin
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = RESP_OKAY;
			case ({awa_r[7:2], 2'b00})
				ADDR_IRQ_EN: if (ws_r[0]) ien_nxt = wd_r[2:0];
				ADDR_IRQ_CLR: if (ws_r[0]) clr = wd_r[2:0];
				ADDR_STATUS, ADDR_IRQ_STAT: br_nxt = RESP_OKAY;
				default: br_nxt = RESP_SLVERR;
			endcase
		end
		else if (bv_r && s_axi_bready)
			bv_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			bv_r <= 1'b0;
			br_r <= RESP_OKAY;
			ien_r <= IRQ_EN_RST;
		end
		else
		begin
			aw_ok_r <= aw_ok_nxt;
			w_ok_r <= w_ok_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			ien_r <= ien_nxt;
		end
	end

	assign s_axi_awready = !aw_ok_r && !bv_r;
	assign s_axi_wready = !w_ok_r && !bv_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;

	////////////////////////////////////////////////////////////////
	// read channel: one cycle from address to data
	logic rv_r, rv_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [1:0] rr_r, rr_nxt;

	always_comb
	begin
		rv_nxt = rv_r;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		if (s_axi_arvalid && !rv_r)
		begin
			rv_nxt = 1'b1;
			rd_nxt = 32'h0;
			rr_nxt = RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				ADDR_STATUS:
				begin
					rd_nxt[5:0] = pos_w[0];
					rd_nxt[ST_POS_B +: 6] = pos_w[1];
					rd_nxt[ST_THERM] = therm_stop;
					rd_nxt[ST_HOLD] = hold;
					rd_nxt[ST_MODE +: 2] = mode;
				end
				ADDR_IRQ_STAT: rd_nxt[2:0] = ist_r;
				ADDR_IRQ_EN: rd_nxt[2:0] = ien_r;
				ADDR_IRQ_CLR: rr_nxt = RESP_OKAY;
				default: rr_nxt = RESP_SLVERR;
			endcase
		end
		else if (rv_r && s_axi_rready)
			rv_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rv_r <= 1'b0;
			rd_r <= 32'h0;
			rr_r <= RESP_OKAY;
		end
		else
		begin
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
		end
	end

	assign s_axi_arready = !rv_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;

	////////////////////////////////////////////////////////////////
	// checks
	a_clear_float: assert property (@(posedge aclk) disable iff (!aresetn) // R14
		!chip_clear_low |=> !bridge_en_pair_a && !bridge_en_pair_b) else $error("bridge on in clear");
	a_lockout_float: assert property (@(posedge aclk) disable iff (!aresetn) // R09
		supply_low_lockout |=> !bridge_en_pair_a && !phase_peak_flag_pair_a_oe)
		else $error("active under lockout");
	a_off_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		!output_force_off_pair_a && !hold |=> !bridge_en_pair_a && !phase_peak_flag_pair_a_oe)
		else $error("force-off ignored");
	a_therm_stop: assert property (@(posedge aclk) disable iff (!aresetn) // R10
		thermal_shutdown && !hold ##1 1 |-> !bridge_en_pair_b) else $error("overheat ignored");
	a_therm_mask: assert property (@(posedge aclk) disable iff (!aresetn) // R11
		hold |=> !ist_r[IRQ_THERM] || $past(ist_r[IRQ_THERM]))
		else $error("overheat active during clear");
	a_start_axis: assert property (@(posedge aclk) disable iff (!aresetn) // R04
		hold && mode == MD_MICRO ##1 chip_clear_low && !supply_low_lockout && output_force_off_pair_a
		|=> target_w1_pair_a == 8'sh64 && target_w2_pair_a == 8'sh00) else $error("start target");
	a_peak_micro: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		shape_w[0] == MD_MICRO && pos_w[0][3:0] == 4'h0 && en_nxt[0] |=> phase_peak_flag_pair_a_oe)
		else $error("peak flag missed");
	a_fwd_lag: assert property (@(posedge aclk) disable iff (!aresetn) // R02
		shape_w[0] == MD_MICRO && pos_w[0] == 6'h10 |=> target_w1_pair_a == 8'sh00
		&& target_w2_pair_a == 8'sh64) else $error("winding phase order");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		(ist_r & ien_r) != 3'h0 |-> irq) else $error("irq low with enabled event");
	c_full_mode: cover property (@(posedge aclk) disable iff (!aresetn)
		shape_w[0] == MD_FULL && pos_w[0] == 6'h18);
	c_therm: cover property (@(posedge aclk) disable iff (!aresetn) therm_stop);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq && s_axi_bvalid);
endmodule

// ===== sim/psmi_host.sv
// step pulse source standing in for the sequencer of one channel pair
module psmi_host
(
	input wire logic aclk,
	output logic step,
	output logic rot
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle low so no spurious rise is seen at start
	initial
	begin
		step = 1'b0;
		rot = 1'b1;
	end
	// direction settles a cycle ahead of the rise and holds across it
	task automatic pulse(input int n, input logic f, input int gap);
		repeat (n)
		begin
			@(posedge aclk);
			rot <= f;
			@(posedge aclk);
			step <= 1'b1;
			@(posedge aclk);
			step <= 1'b0;
			repeat (gap) @(posedge aclk);
		end
	endtask
endmodule

// ===== sim/test_pulse_step_motor_indexer.sv
// self-checking bench of the two-pair step indexer
module test_pulse_step_motor_indexer
	import psmi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [33:0] v; logic [33:0] m;} psmi_note_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic chip_clear_low = 1'b1, supply_low_lockout = 1'b0, thermal_shutdown = 1'b0;
	logic drive_select_pin_1 = 1'b0, drive_select_pin_2 = 1'b1;
	logic drive_select_pin_3 = 1'b0, drive_select_pin_4 = 1'b0;
	logic output_force_off_pair_a = 1'b1, output_force_off_pair_b = 1'b1;
	logic step_pulse_pair_a, step_pulse_pair_b, rotation_select_pair_a, rotation_select_pair_b;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic signed [7:0] target_w1_pair_a, target_w2_pair_a, target_w1_pair_b, target_w2_pair_b;
	logic bridge_en_pair_a, bridge_en_pair_b, phase_peak_flag_pair_a_o, phase_peak_flag_pair_a_oe;
	logic phase_peak_flag_pair_b_o, phase_peak_flag_pair_b_oe;
	logic snap_r = 1'b0;
	logic [31:0] seed = 32'hb725;
	psmi_note_t q[$];
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	////////////////////////////////////////////////////////////////////////////////
	psmi_top u_psmi_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_clear_low, .supply_low_lockout,
		.thermal_shutdown, .step_pulse_pair_a, .step_pulse_pair_b, .rotation_select_pair_a,
		.rotation_select_pair_b, .drive_select_pin_1, .drive_select_pin_2,
		.drive_select_pin_3, .drive_select_pin_4, .output_force_off_pair_a,
		.output_force_off_pair_b, .target_w1_pair_a, .target_w2_pair_a, .target_w1_pair_b,
		.target_w2_pair_b, .bridge_en_pair_a, .bridge_en_pair_b, .phase_peak_flag_pair_a_o,
		.phase_peak_flag_pair_a_oe, .phase_peak_flag_pair_b_o, .phase_peak_flag_pair_b_oe,
		.irq);
	psmi_host u_host_a (.aclk, .step(step_pulse_pair_a), .rot(rotation_select_pair_a));
	psmi_host u_host_b (.aclk, .step(step_pulse_pair_b), .rot(rotation_select_pair_b));
	////////////////////////////////////////////////////////////////////////////////
	// clock, and a snapshot word of pair a outputs or the read answer
	always #2 aclk = ~aclk;
	wire logic [33:0] obs = snap_r ? {2'h0, target_w1_pair_a, target_w2_pair_a, 13'h0, irq,
		bridge_en_pair_a, phase_peak_flag_pair_a_oe} : {s_axi_rresp, s_axi_rdata};
	// oldest note against whatever result shows at this edge
	always @(posedge aclk)
	begin
		if ((s_axi_rvalid && s_axi_rready) || snap_r)
		begin
			cmp_count++;
			if (q.size() == 0 || ((obs ^ q[0].v) & q[0].m) !== 34'h0)
			begin
				err_total++;
				$display("unexpected at %0t: got %h", $time, obs);
			end
			if (q.size() != 0)
				void'(q.pop_front());
		end
	end
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic w(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	// each channel drops its valid once its own ready was seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// the loop test sees the values before this edge's releases land
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid)
				s_axi_bready <= 1'b0;
		end
		while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] v, input logic [33:0] m);
		q.push_back(psmi_note_t'{v, m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid)
				s_axi_rready <= 1'b0;
		end
		while (s_axi_arvalid || s_axi_rready);
	endtask
	// flags are irq, bridge enable, peak pull-down; tm masks the targets
	task automatic chk(input logic signed [7:0] t1, input logic signed [7:0] t2,
		input logic [2:0] f, input logic [2:0] fm, input logic tm);
		q.push_back(psmi_note_t'{{2'h0, t1, t2, 13'h0, f}, {2'h0, {16{tm}}, 13'h0, fm}});
		@(posedge aclk);
		snap_r <= 1'b1;
		@(posedge aclk);
		snap_r <= 1'b0;
	endtask
	// unused select pins get noise to show they are ignored
	task automatic setm(input psmi_mode_t m);
		drive_select_pin_1 <= (m == MD_HALF);
		drive_select_pin_2 <= (m == MD_MICRO);
		drive_select_pin_3 <= ^xs();
		drive_select_pin_4 <= ^xs();
	endtask
	task automatic clear(input psmi_mode_t m);
		setm(m);
		chip_clear_low <= 1'b0;
		w(2);
		chip_clear_low <= 1'b1;
		w(3);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence, one pass through the behaviours
	initial
	begin
		w(4);
		aresetn <= 1'b1;
		rd(ADDR_IRQ_EN, 34'h0, 34'h7);
		rd(8'h40, {RESP_SLVERR, 32'h0}, 34'h3ffffffff);
		clear(MD_MICRO);
		chk(8'sd100, 8'sd0, 3'b011, 3'b011, 1'b1);
		done("start");
		wr(ADDR_IRQ_CLR, 32'h7);
		wr(ADDR_IRQ_EN, 32'h1);
		u_host_a.pulse(1, 1'b1, 0);
		chk(8'sd0, 8'sd0, 3'b010, 3'b111, 1'b0);
		u_host_a.pulse(15, 1'b1, xs() % 4);
		chk(8'sd0, 8'sd100, 3'b111, 3'b111, 1'b1);
		rd(ADDR_STATUS, 34'h80010, 34'hc003f);
		rd(ADDR_IRQ_STAT, 34'h1, 34'h1);
		wr(ADDR_IRQ_CLR, 32'h1);
		chk(8'sd0, 8'sd0, 3'b000, 3'b100, 1'b0);
		done("micro");
		u_host_a.pulse(32, 1'b0, 0);
		chk(8'sd0, -8'sd100, 3'b011, 3'b011, 1'b1);
		rd(ADDR_STATUS, 34'h30, 34'h3f);
		n = 1 + xs() % 15;
		u_host_b.pulse(n, 1'b1, 1);
		rd(ADDR_STATUS, 34'((n << 8) | 48), 34'h3f3f);
		done("reverse");
		clear(MD_FULL);
		chk(8'sd100, 8'sd100, 3'b011, 3'b011, 1'b1);
		u_host_a.pulse(1, 1'b1, 0);
		chk(-8'sd100, 8'sd100, 3'b010, 3'b011, 1'b1);
		u_host_a.pulse(3, 1'b1, 0);
		rd(ADDR_STATUS, 34'h8, 34'hc003f);
		done("full");
		clear(MD_HALF);
		chk(8'sd100, 8'sd0, 3'b010, 3'b011, 1'b1);
		u_host_a.pulse(1, 1'b1, 0);
		chk(8'sd100, 8'sd100, 3'b011, 3'b011, 1'b1);
		u_host_a.pulse(7, 1'b1, 0);
		rd(ADDR_STATUS, 34'h40000, 34'hc003f);
		done("half");
		clear(MD_MICRO);
		u_host_a.pulse(3, 1'b1, 0);
		setm(MD_FULL);
		w(4);
		rd(ADDR_STATUS, 34'h3, 34'h3f);
		u_host_a.pulse(1, 1'b1, 0);
		rd(ADDR_STATUS, 34'h8, 34'hf);
		u_host_a.pulse(1, 1'b1, 0);
		rd(ADDR_STATUS, 34'h8, 34'hf);
		done("switch");
		chip_clear_low <= 1'b0;
		w(2);
		chk(8'sd0, 8'sd0, 3'b000, 3'b011, 1'b0);
		u_host_a.pulse(2, 1'b1, 0);
		chip_clear_low <= 1'b1;
		w(3);
		rd(ADDR_STATUS, 34'h8, 34'h3f);
		supply_low_lockout <= 1'b1;
		u_host_a.pulse(2, 1'b1, 0);
		chk(8'sd0, 8'sd0, 3'b000, 3'b010, 1'b0);
		supply_low_lockout <= 1'b0;
		w(3);
		rd(ADDR_STATUS, 34'h8, 34'h3f);
		done("clear");
		wr(ADDR_IRQ_CLR, 32'h7);
		wr(ADDR_IRQ_EN, 32'h4);
		thermal_shutdown <= 1'b1;
		w(3);
		chk(8'sd0, 8'sd0, 3'b100, 3'b110, 1'b0);
		u_host_a.pulse(2, 1'b1, 0);
		rd(ADDR_STATUS, 34'h10008, 34'h1003f);
		chip_clear_low <= 1'b0;
		w(3);
		rd(ADDR_STATUS, 34'h0, 34'h10000);
		thermal_shutdown <= 1'b0;
		chip_clear_low <= 1'b1;
		w(3);
		done("heat");
		output_force_off_pair_a <= 1'b0;
		output_force_off_pair_b <= 1'b0;
		w(3);
		chk(8'sd0, 8'sd0, 3'b000, 3'b011, 1'b0);
		output_force_off_pair_a <= 1'b1;
		output_force_off_pair_b <= 1'b1;
		w(3);
		chk(8'sd100, 8'sd100, 3'b011, 3'b011, 1'b1);
		done("off");
		complete_run();
	end
endmodule
